// File: dfsb_bank.sv
/*
 diag fault status bank: read-only fault status registers of a battery
 monitor, an apb slave, and a masked read-to-clear interrupt.
 assumes diagnostic engines on clk give a one-cycle done strobe with
 their result, comparator and supply fault levels come asynchronously,
 and a separate fault-clear block pulses fault_clear per register.
*/
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - eight undertemperature bits, bit n for auxiliary input n+1.
// - auxiliary pin main versus aux adc compare: 1 fail, 0 pass.
// - cells one to six voltage compare fail bits; bits 7 and 6 reserved.
// - cells one to six input open-wire fail bits; pass reads zero.
// - balancing switch open-wire results in bits 0 to 5, 1 fail.
// - balancing switch transistor results in bits 0 to 5, 1 fail.
// - bit 1 flags last adc compare run aborted on bad setting.
// - bit 0 of misc compare holds filter diagnostic result.
// - open core ground, digital ground, high reference return in bits 7,6,5.
// - core uv bit 4, core ov bit 3, digital ov bit 2, analog ov bit 0.
// - bit 1 flags analog supply oscillation outside its limits.
module dfsb_bank
	import dfsb_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [DFSB_ADDR_W-1:0] paddr,
	input  wire logic [DFSB_DATA_W-1:0] pwdata,
	output logic      [DFSB_DATA_W-1:0] prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        irq,
	input  wire logic [DFSB_REG_W-1:0]  undertemp_detect_bit,
	input  wire logic [DFSB_REG_W-1:0]  supply_fault_raw,
	input  wire logic                   pin_cmp_done,
	input  wire logic [DFSB_REG_W-1:0]  aux_pin_compare_fail,
	input  wire logic                   cell_cmp_done,
	input  wire logic [DFSB_CH6_W-1:0]  channel_voltage_compare_fail,
	input  wire logic                   input_ow_done,
	input  wire logic [DFSB_CH6_W-1:0]  input_open_wire_fail,
	input  wire logic                   bal_ow_done,
	input  wire logic [DFSB_CH6_W-1:0]  balance_open_wire_fail,
	input  wire logic                   bal_sw_done,
	input  wire logic [DFSB_CH6_W-1:0]  balance_switch_fail,
	input  wire logic                   adc_cmp_done,
	input  wire logic                   adc_cmp_abort,
	input  wire logic                   filter_diag_done,
	input  wire logic                   filter_diag_fail,
	input  wire logic [DFSB_NREG-1:0]   fault_clear
);

	logic [DFSB_NPIN-1:0]    pin_raw;
	logic [DFSB_NPIN-1:0]    pin_s1_ff;
	logic [DFSB_NPIN-1:0]    pin_s2_ff;
	logic [DFSB_NPIN-1:0]    pin_s3_ff;
	logic [DFSB_NPIN-1:0]    pin_ok_ff;
	logic [DFSB_REG_W-1:0]   ut_lvl;
	logic [DFSB_REG_W-1:0]   pwr_lvl;

	logic [DFSB_REG_W-1:0]   undertemp_status_ff;
	logic [DFSB_REG_W-1:0]   aux_pin_compare_status_ff;
	logic [DFSB_CH6_W-1:0]   cell_compare_status_ff;
	logic [DFSB_CH6_W-1:0]   input_open_wire_status_ff;
	logic [DFSB_CH6_W-1:0]   balance_open_wire_status_ff;
	logic [DFSB_CH6_W-1:0]   balance_switch_status_ff;
	logic [DFSB_MISC_W-1:0]  misc_compare_status_ff;
	logic [DFSB_REG_W-1:0]   supply_fault_status_one_ff;

	logic [DFSB_REG_W-1:0]   nxt_undertemp_status;
	logic [DFSB_REG_W-1:0]   nxt_aux_pin_compare_status;
	logic [DFSB_CH6_W-1:0]   nxt_cell_compare_status;
	logic [DFSB_CH6_W-1:0]   nxt_input_open_wire_status;
	logic [DFSB_CH6_W-1:0]   nxt_balance_open_wire_status;
	logic [DFSB_CH6_W-1:0]   nxt_balance_switch_status;
	logic [DFSB_MISC_W-1:0]  nxt_misc_compare_status;
	logic [DFSB_REG_W-1:0]   nxt_supply_fault_status_one;

	logic [DFSB_NREG-1:0]    int_status_ff;
	logic [DFSB_NREG-1:0]    nxt_int_status;
	logic [DFSB_NREG-1:0]    int_mask_ff;
	logic [DFSB_NREG-1:0]    ev;

	logic [DFSB_IDX_W-1:0]   idx;
	logic                    aligned;
	logic                    hit;
	logic                    take;
	logic                    done;
	logic [DFSB_DATA_W-1:0]  rdata;

	logic [DFSB_DATA_W-1:0]  prdata_ff;
	logic                    pready_ff;
	logic                    pslverr_ff;
	logic                    irq_ff;

	// comparator and supply levels come from analog, so resynchronise
	assign pin_raw = {supply_fault_raw, undertemp_detect_bit};

	generate
		for (genvar i = 0; i < DFSB_NPIN; i++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					pin_s1_ff[i] <= 1'b0;
					pin_s2_ff[i] <= 1'b0;
					pin_s3_ff[i] <= 1'b0;
				end else if (ce) begin
					pin_s1_ff[i] <= pin_raw[i];
					pin_s2_ff[i] <= pin_s1_ff[i];
					pin_s3_ff[i] <= pin_s2_ff[i];
				end
			end

			// a change is accepted only once stages two and three agree
			always_ff @(posedge clk) begin
				if (rst) begin
					pin_ok_ff[i] <= 1'b0;
				end else if (ce && (pin_s2_ff[i] == pin_s3_ff[i])) begin
					pin_ok_ff[i] <= pin_s3_ff[i];
				end
			end
		end
	endgenerate

	assign ut_lvl  = pin_ok_ff[DFSB_REG_W-1:0];
	assign pwr_lvl = pin_ok_ff[DFSB_NPIN-1:DFSB_REG_W];

	// comparator faults latch until cleared; a live fault beats a clear
	always_comb begin
		nxt_undertemp_status = undertemp_status_ff;
		if (fault_clear[DFSB_EV_UT]) begin
			nxt_undertemp_status = DFSB_RST8;
		end
		nxt_undertemp_status = nxt_undertemp_status | ut_lvl;
	end

	// supply faults keep their bit positions straight from the level vector
	always_comb begin
		nxt_supply_fault_status_one = supply_fault_status_one_ff;
		if (fault_clear[DFSB_EV_PWR1]) begin
			// oscillation flag after wake is cleared here by the host
			nxt_supply_fault_status_one = DFSB_RST8;
		end
		nxt_supply_fault_status_one[DFSB_PWR_CGND_OP] =
			nxt_supply_fault_status_one[DFSB_PWR_CGND_OP] | pwr_lvl[DFSB_PWR_CGND_OP];
		nxt_supply_fault_status_one[DFSB_PWR_DGND_OP] =
			nxt_supply_fault_status_one[DFSB_PWR_DGND_OP] | pwr_lvl[DFSB_PWR_DGND_OP];
		nxt_supply_fault_status_one[DFSB_PWR_HREF_OP] =
			nxt_supply_fault_status_one[DFSB_PWR_HREF_OP] | pwr_lvl[DFSB_PWR_HREF_OP];
		nxt_supply_fault_status_one[DFSB_PWR_CREG_UV] =
			nxt_supply_fault_status_one[DFSB_PWR_CREG_UV] | pwr_lvl[DFSB_PWR_CREG_UV];
		nxt_supply_fault_status_one[DFSB_PWR_CREG_OV] =
			nxt_supply_fault_status_one[DFSB_PWR_CREG_OV] | pwr_lvl[DFSB_PWR_CREG_OV];
		nxt_supply_fault_status_one[DFSB_PWR_DREG_OV] =
			nxt_supply_fault_status_one[DFSB_PWR_DREG_OV] | pwr_lvl[DFSB_PWR_DREG_OV];
		nxt_supply_fault_status_one[DFSB_PWR_AOSC] =
			nxt_supply_fault_status_one[DFSB_PWR_AOSC] | pwr_lvl[DFSB_PWR_AOSC];
		nxt_supply_fault_status_one[DFSB_PWR_AREG_OV] =
			nxt_supply_fault_status_one[DFSB_PWR_AREG_OV] | pwr_lvl[DFSB_PWR_AREG_OV];
	end

	// diagnostic results replace the old ones on each done strobe,
	// so a pass writes zero; a fresh result beats a clear
	always_comb begin
		nxt_aux_pin_compare_status = aux_pin_compare_status_ff;
		if (fault_clear[DFSB_EV_PIN]) begin
			nxt_aux_pin_compare_status = DFSB_RST8;
		end
		if (pin_cmp_done) begin
			nxt_aux_pin_compare_status = aux_pin_compare_fail;
		end
	end

	always_comb begin
		nxt_cell_compare_status = cell_compare_status_ff;
		if (fault_clear[DFSB_EV_CELL]) begin
			nxt_cell_compare_status = DFSB_RST6;
		end
		if (cell_cmp_done) begin
			nxt_cell_compare_status = channel_voltage_compare_fail;
		end
	end

	always_comb begin
		nxt_input_open_wire_status = input_open_wire_status_ff;
		if (fault_clear[DFSB_EV_IOW]) begin
			nxt_input_open_wire_status = DFSB_RST6;
		end
		if (input_ow_done) begin
			nxt_input_open_wire_status = input_open_wire_fail;
		end
	end

	always_comb begin
		nxt_balance_open_wire_status = balance_open_wire_status_ff;
		if (fault_clear[DFSB_EV_BOW]) begin
			nxt_balance_open_wire_status = DFSB_RST6;
		end
		if (bal_ow_done) begin
			nxt_balance_open_wire_status = balance_open_wire_fail;
		end
	end

	always_comb begin
		nxt_balance_switch_status = balance_switch_status_ff;
		if (fault_clear[DFSB_EV_BSW]) begin
			nxt_balance_switch_status = DFSB_RST6;
		end
		if (bal_sw_done) begin
			nxt_balance_switch_status = balance_switch_fail;
		end
	end

	// abort and filter results come from separate engines, each its own strobe
	always_comb begin
		nxt_misc_compare_status = misc_compare_status_ff;
		if (fault_clear[DFSB_EV_MISC]) begin
			nxt_misc_compare_status = DFSB_RST2;
		end
		if (adc_cmp_done) begin
			nxt_misc_compare_status[DFSB_MISC_ABORT] = adc_cmp_abort;
		end
		if (filter_diag_done) begin
			nxt_misc_compare_status[DFSB_MISC_LPF] = filter_diag_fail;
		end
	end

	// status registers are never loaded from the bus
	always_ff @(posedge clk) begin
		if (rst) begin
			undertemp_status_ff         <= DFSB_RST8;
			aux_pin_compare_status_ff   <= DFSB_RST8;
			cell_compare_status_ff      <= DFSB_RST6;
			input_open_wire_status_ff   <= DFSB_RST6;
			balance_open_wire_status_ff <= DFSB_RST6;
			balance_switch_status_ff    <= DFSB_RST6;
			misc_compare_status_ff      <= DFSB_RST2;
			supply_fault_status_one_ff  <= DFSB_RST8;
		end else if (ce) begin
			undertemp_status_ff         <= nxt_undertemp_status;
			aux_pin_compare_status_ff   <= nxt_aux_pin_compare_status;
			cell_compare_status_ff      <= nxt_cell_compare_status;
			input_open_wire_status_ff   <= nxt_input_open_wire_status;
			balance_open_wire_status_ff <= nxt_balance_open_wire_status;
			balance_switch_status_ff    <= nxt_balance_switch_status;
			misc_compare_status_ff      <= nxt_misc_compare_status;
			supply_fault_status_one_ff  <= nxt_supply_fault_status_one;
		end
	end

	// an event is any status bit going from zero to one
	always_comb begin
		ev = '0;
		ev[DFSB_EV_UT]   = |(nxt_undertemp_status & ~undertemp_status_ff);
		ev[DFSB_EV_PIN]  = |(nxt_aux_pin_compare_status & ~aux_pin_compare_status_ff);
		ev[DFSB_EV_CELL] = |(nxt_cell_compare_status & ~cell_compare_status_ff);
		ev[DFSB_EV_IOW]  = |(nxt_input_open_wire_status & ~input_open_wire_status_ff);
		ev[DFSB_EV_BOW]  = |(nxt_balance_open_wire_status & ~balance_open_wire_status_ff);
		ev[DFSB_EV_BSW]  = |(nxt_balance_switch_status & ~balance_switch_status_ff);
		ev[DFSB_EV_MISC] = |(nxt_misc_compare_status & ~misc_compare_status_ff);
		ev[DFSB_EV_PWR1] = |(nxt_supply_fault_status_one & ~supply_fault_status_one_ff);
	end

	// apb decode; one wait state keeps read data straight from a flop
	assign idx     = paddr[DFSB_ADDR_W-1:2];
	assign aligned = (paddr[1:0] == DFSB_ALIGN);
	assign take    = psel & penable & ~pready_ff;
	assign done    = psel & penable & pready_ff;

	always_comb begin
		hit   = aligned;
		rdata = DFSB_RST32;
		case (idx)
			DFSB_IDX_UT: begin
				rdata = {{DFSB_PAD8_W{1'b0}}, undertemp_status_ff};
			end
			DFSB_IDX_PIN: begin
				rdata = {{DFSB_PAD8_W{1'b0}}, aux_pin_compare_status_ff};
			end
			DFSB_IDX_CELL: begin
				rdata = {{DFSB_PAD6_W{1'b0}}, cell_compare_status_ff};
			end
			DFSB_IDX_IOW: begin
				rdata = {{DFSB_PAD6_W{1'b0}}, input_open_wire_status_ff};
			end
			DFSB_IDX_BOW: begin
				rdata = {{DFSB_PAD6_W{1'b0}}, balance_open_wire_status_ff};
			end
			DFSB_IDX_BSW: begin
				rdata = {{DFSB_PAD6_W{1'b0}}, balance_switch_status_ff};
			end
			DFSB_IDX_MISC: begin
				rdata = {{DFSB_PAD2_W{1'b0}}, misc_compare_status_ff};
			end
			DFSB_IDX_PWR1: begin
				rdata = {{DFSB_PAD8_W{1'b0}}, supply_fault_status_one_ff};
			end
			DFSB_IDX_INTST: begin
				rdata = {{DFSB_PAD8_W{1'b0}}, int_status_ff};
			end
			DFSB_IDX_INTMK: begin
				rdata = {{DFSB_PAD8_W{1'b0}}, int_mask_ff};
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff <= 1'b0;
		end else if (ce) begin
			pready_ff <= take;
		end
	end

	// writes to status addresses complete without error and change nothing
	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr_ff <= 1'b0;
		end else if (ce) begin
			pslverr_ff <= take & ~hit;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_ff <= DFSB_RST32;
		end else if (ce && take) begin
			prdata_ff <= pwrite ? DFSB_RST32 : rdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			int_mask_ff <= DFSB_RST8;
		end else if (ce && done && pwrite && aligned && (idx == DFSB_IDX_INTMK)) begin
			int_mask_ff <= pwdata[DFSB_NREG-1:0];
		end
	end

	// read clear happens at the edge the data is captured, and a new
	// event in that same edge survives
	always_comb begin
		nxt_int_status = int_status_ff;
		if (take && !pwrite && aligned && (idx == DFSB_IDX_INTST)) begin
			nxt_int_status = DFSB_RST8;
		end
		nxt_int_status = nxt_int_status | ev;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			int_status_ff <= DFSB_RST8;
		end else if (ce) begin
			int_status_ff <= nxt_int_status;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= |(nxt_int_status & int_mask_ff);
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;

endmodule

// File: dfsb_pkg.sv
/*
 diag fault status bank package: register indices, field positions,
 widths and reset values shared by the bank and its bench.
 assumes an apb slave with 32-bit data and word-aligned registers.
*/
package dfsb_pkg;
	localparam int DFSB_ADDR_W = 16;
	localparam int DFSB_DATA_W = 32;
	localparam int DFSB_IDX_W  = 14;
	localparam int DFSB_REG_W  = 8;
	localparam int DFSB_CH6_W  = 6;
	localparam int DFSB_MISC_W = 2;
	localparam int DFSB_NREG   = 8;
	localparam int DFSB_PAD8_W = DFSB_DATA_W - DFSB_REG_W;
	localparam int DFSB_PAD6_W = DFSB_DATA_W - DFSB_CH6_W;
	localparam int DFSB_PAD2_W = DFSB_DATA_W - DFSB_MISC_W;
	localparam int DFSB_NPIN   = 2 * DFSB_REG_W;
	// byte address = index * 4
	localparam logic [1:0] DFSB_ALIGN = 2'h0;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_UT    = 14'h0541;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_PIN   = 14'h0543;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_CELL  = 14'h0546;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_IOW   = 14'h0549;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_BOW   = 14'h054C;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_BSW   = 14'h054F;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_MISC  = 14'h0550;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_PWR1  = 14'h0552;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_INTST = 14'h0560;
	localparam logic [DFSB_IDX_W-1:0] DFSB_IDX_INTMK = 14'h0561;
	// positions in the interrupt status, mask and fault clear vectors
	localparam int DFSB_EV_UT   = 0;
	localparam int DFSB_EV_PIN  = 1;
	localparam int DFSB_EV_CELL = 2;
	localparam int DFSB_EV_IOW  = 3;
	localparam int DFSB_EV_BOW  = 4;
	localparam int DFSB_EV_BSW  = 5;
	localparam int DFSB_EV_MISC = 6;
	localparam int DFSB_EV_PWR1 = 7;
	// misc compare field positions
	localparam int DFSB_MISC_LPF   = 0;
	localparam int DFSB_MISC_ABORT = 1;
	// supply fault field positions
	localparam int DFSB_PWR_AREG_OV  = 0;
	localparam int DFSB_PWR_AOSC     = 1;
	localparam int DFSB_PWR_DREG_OV  = 2;
	localparam int DFSB_PWR_CREG_OV  = 3;
	localparam int DFSB_PWR_CREG_UV  = 4;
	localparam int DFSB_PWR_HREF_OP  = 5;
	localparam int DFSB_PWR_DGND_OP  = 6;
	localparam int DFSB_PWR_CGND_OP  = 7;
	localparam logic [DFSB_REG_W-1:0]  DFSB_RST8 = 8'h00;
	localparam logic [DFSB_CH6_W-1:0]  DFSB_RST6 = 6'h00;
	localparam logic [DFSB_MISC_W-1:0] DFSB_RST2 = 2'h0;
	localparam logic [DFSB_DATA_W-1:0] DFSB_RST32 = 32'h0000_0000;
endpackage

// File: dfsb_bank_sva.sv
/*
 checker for the diag fault status bank, bound to its ports.
 assumes ce high during apb transfers and a legal apb master.
*/
`timescale 1ns/1ps
module dfsb_bank_sva
	import dfsb_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   ce,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [DFSB_ADDR_W-1:0] paddr,
	input wire logic [DFSB_DATA_W-1:0] prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   irq,
	input wire logic                   pin_cmp_done,
	input wire logic [DFSB_REG_W-1:0]  aux_pin_compare_fail,
	input wire logic                   adc_cmp_done,
	input wire logic                   adc_cmp_abort,
	input wire logic                   filter_diag_done,
	input wire logic                   filter_diag_fail,
	input wire logic [DFSB_NREG-1:0]   fault_clear
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	localparam logic [15:0] A_PIN = {DFSB_IDX_PIN, 2'h0};
	localparam logic [15:0] A_CELL = {DFSB_IDX_CELL, 2'h0};
	localparam logic [15:0] A_MISC = {DFSB_IDX_MISC, 2'h0};
	logic [7:0] pin_ff;
	logic [1:0] misc_ff;
	logic       rd;
	assign rd = psel && penable && pready && !pwrite;
	// shadow of the last loaded results; done wins over a clear
	always_ff @(posedge clk) begin
		if (rst)
			pin_ff <= 8'h00;
		else if (ce && pin_cmp_done)
			pin_ff <= aux_pin_compare_fail;
		else if (ce && fault_clear[DFSB_EV_PIN])
			pin_ff <= 8'h00;
	end
	always_ff @(posedge clk) begin
		if (rst)
			misc_ff <= 2'h0;
		else if (ce) begin
			if (fault_clear[DFSB_EV_MISC])
				misc_ff <= 2'h0;
			if (adc_cmp_done)
				misc_ff[1] <= adc_cmp_abort;
			if (filter_diag_done)
				misc_ff[0] <= filter_diag_fail;
		end
	end
	property p_reset_zero;
		$fell(rst) |-> !pready && !irq && prdata == 32'h0000_0000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");
	property p_answer;
		ce && psel && penable && !pready && !$past(penable) |=> pready;
	endproperty
	a_answer: assert property (p_answer) else $error("apb answer late");
	property p_upper_zero;
		rd && !pslverr |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
	property p_cell_rsvd;
		rd && paddr == A_CELL |-> prdata[7:6] == 2'h0;
	endproperty
	a_cell_rsvd: assert property (p_cell_rsvd) else $error("cell reserved bits set");
	property p_pin_load;
		rd && paddr == A_PIN && !$past(pin_cmp_done) |-> prdata[7:0] == pin_ff;
	endproperty
	a_pin_load: assert property (p_pin_load) else $error("pin compare read wrong");
	property p_abort;
		rd && paddr == A_MISC && !$past(adc_cmp_done) |-> prdata[1] == misc_ff[1] && prdata[7:2] == 6'h00;
	endproperty
	a_abort: assert property (p_abort) else $error("abort bit wrong");
	property p_filter;
		rd && paddr == A_MISC && !$past(filter_diag_done) |-> prdata[0] == misc_ff[0];
	endproperty
	a_filter: assert property (p_filter) else $error("filter bit wrong");
	property p_wr_none;
		psel && penable && pready && pwrite && paddr == A_PIN |-> !pslverr && prdata == 32'h0000_0000;
	endproperty
	a_wr_none: assert property (p_wr_none) else $error("status write misbehaved");
	property p_unmapped;
		rd && pslverr |-> prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("error read data not zero");
	c_err: cover property (rd && pslverr);
	c_irq: cover property ($rose(irq));
	c_pin: cover property (pin_cmp_done && aux_pin_compare_fail != 8'h00);
endmodule
bind dfsb_bank dfsb_bank_sva u_dfsb_bank_sva (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.pin_cmp_done(pin_cmp_done), .aux_pin_compare_fail(aux_pin_compare_fail), .adc_cmp_done(adc_cmp_done),
	.adc_cmp_abort(adc_cmp_abort), .filter_diag_done(filter_diag_done), .filter_diag_fail(filter_diag_fail),
	.fault_clear(fault_clear));

// File: dfsb_bank_test.sv
/*
 self-checking bench for the diag fault status bank.
 assumes the bank answers apb with pready and ce may stay high.
*/
`timescale 1ns/1ps
module dfsb_bank_test;
	import dfsb_pkg::*;
	logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  ut, sup, pinr, fclr;
	logic [5:0]  cellr, iowr, bowr, bswr;
	logic        pind, celld, iowd, bowd, bswd, adcd, adca, fild, filf;
	int          errors, tests_run;
	logic [13:0] idx [8];
	dfsb_bank u_dfsb_bank (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.undertemp_detect_bit(ut), .supply_fault_raw(sup), .pin_cmp_done(pind), .aux_pin_compare_fail(pinr),
		.cell_cmp_done(celld), .channel_voltage_compare_fail(cellr), .input_ow_done(iowd),
		.input_open_wire_fail(iowr), .bal_ow_done(bowd), .balance_open_wire_fail(bowr), .bal_sw_done(bswd),
		.balance_switch_fail(bswr), .adc_cmp_done(adcd), .adc_cmp_abort(adca), .filter_diag_done(fild),
		.filter_diag_fail(filf), .fault_clear(fclr));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic stop_test;
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic rdc(input logic [13:0] i, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, i, 32'h0000_0000, r, e);
		chk($sformatf("reg %h", i), x, r);
		chk("pslverr", {31'h0, xe}, {31'h0, e});
	endtask
	task automatic run(input int k, input logic [7:0] v);
		@(posedge clk);
		case (k)
			0: begin pind <= 1'b1; pinr <= v; end
			1: begin celld <= 1'b1; cellr <= v[5:0]; end
			2: begin iowd <= 1'b1; iowr <= v[5:0]; end
			3: begin bowd <= 1'b1; bowr <= v[5:0]; end
			4: begin bswd <= 1'b1; bswr <= v[5:0]; end
			default: begin adcd <= 1'b1; fild <= 1'b1; adca <= v[1]; filf <= v[0]; end
		endcase
		@(posedge clk);
		{pind, celld, iowd, bowd, bswd, adcd, fild} <= 7'h00;
	endtask
	task automatic clr(input int b);
		@(posedge clk);
		fclr <= 8'h01 << b;
		@(posedge clk);
		fclr <= 8'h00;
	endtask
	task automatic wirq(input logic x);
		int n;
		n = 0;
		while (irq !== x && n < 8) begin
			@(posedge clk);
			n++;
		end
		chk("irq", {31'h0, x}, {31'h0, irq});
		if (n >= 8)
			stop_test();
	endtask
	task automatic t_reset;
		for (int k = 0; k < 8; k++)
			rdc(idx[k], 32'h0000_0000, 1'b0);
		rdc(DFSB_IDX_INTMK, 32'h0000_0000, 1'b0);
	endtask
	task automatic t_write;
		logic [31:0] r;
		logic        e;
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, idx[k], 32'hFFFF_FFFF, r, e);
			rdc(idx[k], 32'h0000_0000, 1'b0);
		end
		rdc(14'h0542, 32'h0000_0000, 1'b1);
	endtask
	// all-ones result also shows the reserved bits 7:6 stay zero
	task automatic t_compare;
		for (int k = 0; k < 5; k++) begin
			run(k, 8'hFF);
			rdc(idx[k + 1], (k == 0) ? 32'h0000_00FF : 32'h0000_003F, 1'b0);
			run(k, 8'h00);
			rdc(idx[k + 1], 32'h0000_0000, 1'b0);
		end
	endtask
	task automatic t_misc;
		run(5, 8'h02);
		rdc(DFSB_IDX_MISC, 32'h0000_0002, 1'b0);
		run(5, 8'h01);
		rdc(DFSB_IDX_MISC, 32'h0000_0001, 1'b0);
		run(5, 8'hFF);
		rdc(DFSB_IDX_MISC, 32'h0000_0003, 1'b0);
	endtask
	task automatic t_levels;
		ut <= 8'h81;
		repeat (4) @(posedge clk);
		ut <= 8'h00;
		rdc(DFSB_IDX_UT, 32'h0000_0081, 1'b0);
		clr(DFSB_EV_UT);
		rdc(DFSB_IDX_UT, 32'h0000_0000, 1'b0);
		for (int b = 0; b < 8; b++) begin
			sup <= 8'h01 << b;
			repeat (4) @(posedge clk);
			sup <= 8'h00;
			rdc(DFSB_IDX_PWR1, 32'h0000_0001 << b, 1'b0);
			clr(DFSB_EV_PWR1);
			rdc(DFSB_IDX_PWR1, 32'h0000_0000, 1'b0);
		end
	endtask
	// cell event is masked, only the pin event may raise irq
	task automatic t_irq;
		logic [31:0] r;
		logic        e;
		apb(1'b0, DFSB_IDX_INTST, 32'h0000_0000, r, e);
		apb(1'b1, DFSB_IDX_INTMK, 32'h0000_0002, r, e);
		run(1, 8'h3F);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		run(0, 8'h01);
		wirq(1'b1);
		rdc(DFSB_IDX_INTST, 32'h0000_0006, 1'b0);
		wirq(1'b0);
		rdc(DFSB_IDX_INTST, 32'h0000_0000, 1'b0);
	endtask
	// ce low freezes results; a done strobe beats a clear in the same cycle
	task automatic t_hold;
		run(0, 8'h5A);
		ce <= 1'b0;
		run(0, 8'hA5);
		@(posedge clk);
		ce <= 1'b1;
		rdc(DFSB_IDX_PIN, 32'h0000_005A, 1'b0);
		@(posedge clk);
		fclr <= 8'h01 << DFSB_EV_PIN;
		pind <= 1'b1;
		pinr <= 8'h3C;
		@(posedge clk);
		fclr <= 8'h00;
		pind <= 1'b0;
		rdc(DFSB_IDX_PIN, 32'h0000_003C, 1'b0);
		clr(DFSB_EV_PIN);
		rdc(DFSB_IDX_PIN, 32'h0000_0000, 1'b0);
		@(posedge clk);
		adcd <= 1'b1;
		adca <= 1'b0;
		@(posedge clk);
		adcd <= 1'b0;
		rdc(DFSB_IDX_MISC, 32'h0000_0001, 1'b0);
		clr(DFSB_EV_MISC);
		rdc(DFSB_IDX_MISC, 32'h0000_0000, 1'b0);
	endtask
	initial begin
		idx = '{DFSB_IDX_UT, DFSB_IDX_PIN, DFSB_IDX_CELL, DFSB_IDX_IOW, DFSB_IDX_BOW, DFSB_IDX_BSW,
			DFSB_IDX_MISC, DFSB_IDX_PWR1};
		{rst, ce} = 2'h3;
		{psel, penable, pwrite, paddr, pwdata} = 51'h0;
		{ut, sup, pinr, fclr, cellr, iowr, bowr, bswr} = 56'h0;
		{pind, celld, iowd, bowd, bswd, adcd, adca, fild, filf} = 9'h000;
		errors = 0;
		tests_run = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_write();
		t_compare();
		t_misc();
		t_levels();
		t_irq();
		t_hold();
		stop_test();
	end
endmodule
